// ==== rtl/gicp_pkg.sv ====
package gicp_pkg;
   // Code groups of interest, as 8-bit values with K flag kept apart
   localparam logic [7:0] K28_5  = 8'hbc;
   localparam logic [7:0] D10_1  = 8'h2a;
   localparam logic [7:0] D16_2  = 8'h50;
   localparam logic [7:0] D5_6   = 8'hc5;

   // Test pattern generator, x^7 + x^6 + 1
   localparam int         PRBS_LEN  = 7;
   localparam int         PRBS_TAPA = 6;
   localparam int         PRBS_TAPB = 5;
   localparam logic [6:0] PRBS_SEED = 7'h7f;
   localparam logic [2:0] SYNC_CNT  = 3'h7;

   // APB register map, byte addresses
   localparam logic [7:0] ADDR_IRQ_STAT  = 8'h00;
   localparam logic [7:0] ADDR_IRQ_MASK  = 8'h04;
   localparam logic [7:0] ADDR_CHAN_STAT = 8'h08;
   localparam logic [7:0] ADDR_MODE_CTRL = 8'h18;
   localparam int         MODE_BIT       = 15;
   localparam int         EVT_OFF_BASE   = 8;
   localparam int         SYNC_BASE      = 8;
   localparam logic [31:0] REG_RESET     = 32'h0000_0000;

   // One transmit character from the protocol device
   typedef struct packed {
      logic       k;
      logic [7:0] data;
   } gicp_char_t;

   // One received character after the decoder
   typedef struct packed {
      logic       cv;
      logic       k;
      logic [7:0] data;
   } gicp_rx_char_t;

   // APB request and answer
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } gicp_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } gicp_apb_rsp_t;

   // Idle correction state, Gray along the path
   typedef enum logic [1:0] {
      CORR_ON        = 2'b00,
      CORR_ONE_COMMA = 2'b01,
      CORR_OFF       = 2'b11,
      CORR_ONE_DATA  = 2'b10
   } gicp_corr_st_t;
endpackage

// ==== rtl/gicp_idle_prbs.sv ====
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module gicp_idle_prbs
   import gicp_pkg::*;
#(
   parameter int NCH = 8
) (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                rst_b,
   // APB slave
   input  wire gicp_apb_req_t       apb_req,
   output gicp_apb_rsp_t            apb_rsp,
   // Mode pins
   input  wire logic                gigabit_idle_mode_pin,
   input  wire logic                busy_pass_enable_pin,
   input  wire logic                test_pattern_enable,
   // Transmit character path
   input  wire gicp_char_t [NCH-1:0] tx_char_i,
   output gicp_char_t [NCH-1:0]     tx_char_o,
   // Receive character path
   input  wire gicp_rx_char_t [NCH-1:0] rx_char_i,
   output logic [NCH-1:0]           rx_idle_o,
   // Serial test pattern bits
   output logic [NCH-1:0]           tx_test_bit_o,
   input  wire logic [NCH-1:0]      rx_test_bit_i,
   // Interrupt
   output logic                     irq
);

   logic [31:0]    irq_stat_reg;
   logic [31:0]    irq_stat_next;
   logic [31:0]    irq_mask_reg;
   logic           mode_bit_reg;
   logic           idle_mode;
   logic           busy_pass_mode;
   logic [NCH-1:0] prbs_err_evt;
   logic [NCH-1:0] corr_off_evt;
   logic [NCH-1:0] corr_en;
   logic [NCH-1:0] chk_sync;
   logic [31:0]    evt_set;
   logic [31:0]    w1c;
   logic           wr_acc;
   logic           rd_acc;
   logic           hit;

   // Effective mode and busy pass level
   assign idle_mode      = gigabit_idle_mode_pin | mode_bit_reg;
   assign busy_pass_mode = busy_pass_enable_pin;

   // APB decode; slave answers with no wait state
   assign wr_acc = apb_req.psel & apb_req.penable & apb_req.pwrite;
   assign rd_acc = apb_req.psel & apb_req.penable & ~apb_req.pwrite;
   always_comb begin
      hit = 1'b1;
      case (apb_req.paddr)
         ADDR_IRQ_STAT, ADDR_IRQ_MASK,
         ADDR_CHAN_STAT, ADDR_MODE_CTRL: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end

   // Read mux; unmapped reads return zero with an error flag
   always_comb begin
      apb_rsp.pready  = 1'b1;
      apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~hit;
      apb_rsp.prdata  = 32'h0000_0000;
      if (rd_acc) begin
         case (apb_req.paddr)
            ADDR_IRQ_STAT:  apb_rsp.prdata = irq_stat_reg;
            ADDR_IRQ_MASK:  apb_rsp.prdata = irq_mask_reg;
            ADDR_CHAN_STAT: begin
               apb_rsp.prdata[NCH-1:0] = corr_en;
               apb_rsp.prdata[SYNC_BASE +: NCH] = chk_sync;
            end
            ADDR_MODE_CTRL: apb_rsp.prdata[MODE_BIT] = mode_bit_reg;
            default:        apb_rsp.prdata = 32'h0000_0000;
         endcase
      end
   end

   // Mode control bit
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_bit_reg <= 1'b0;
      end else if (wr_acc && apb_req.paddr == ADDR_MODE_CTRL) begin
         mode_bit_reg <= apb_req.pwdata[MODE_BIT];
      end
   end

   // Interrupt mask
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_mask_reg <= REG_RESET;
      end else if (wr_acc && apb_req.paddr == ADDR_IRQ_MASK) begin
         irq_mask_reg <= apb_req.pwdata;
      end
   end

   // Sticky events; a new event beats a same-cycle write-one clear
   always_comb begin
      evt_set = 32'h0000_0000;
      evt_set[NCH-1:0] = prbs_err_evt;
      evt_set[EVT_OFF_BASE +: NCH] = corr_off_evt;
      w1c = (wr_acc && apb_req.paddr == ADDR_IRQ_STAT) ?
            apb_req.pwdata : 32'h0000_0000;
      irq_stat_next = (irq_stat_reg & ~w1c) | evt_set;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_stat_reg <= REG_RESET;
      end else begin
         irq_stat_reg <= irq_stat_next;
      end
   end

   assign irq = |(irq_stat_reg & irq_mask_reg);

   // Per-channel idle handling and test pattern logic
   for (genvar ch = 0; ch < NCH; ch++) begin : g_chan
      gicp_corr_st_t st_reg;
      gicp_corr_st_t st_next;
      gicp_char_t    tc;
      gicp_rx_char_t rc;
      logic          tx_comma;
      logic          tx_prev_comma_reg;
      logic          rx_prev_comma_reg;
      logic          sub;
      logic [6:0]    gen_reg;
      logic [6:0]    chk_reg;
      logic [2:0]    cnt_reg;
      logic          predict;

      assign tc       = tx_char_i[ch];
      assign rc       = rx_char_i[ch];
      assign tx_comma = tc.k && tc.data == K28_5;

      // Comma-run tracker; K28.5 runs suspend correction
      always_comb begin
         st_next = st_reg;
         case (st_reg)
            CORR_ON: begin
               if (tx_comma) st_next = CORR_ONE_COMMA;
            end
            CORR_ONE_COMMA: begin
               if (tx_comma) st_next = CORR_OFF;
               else          st_next = CORR_ON;
            end
            CORR_OFF: begin
               if (!tc.k) st_next = CORR_ONE_DATA;
            end
            CORR_ONE_DATA: begin
               if (!tc.k) st_next = CORR_ON;
               else       st_next = CORR_OFF;
            end
            default: st_next = CORR_ON;
         endcase
      end

      // Starts enabled so the first idle is already corrected
      always_ff @(posedge clk or negedge rst_b) begin
         if (!rst_b) begin
            st_reg <= CORR_ON;
         end else begin
            st_reg <= st_next;
         end
      end

      assign corr_en[ch] = st_reg == CORR_ON ||
                           st_reg == CORR_ONE_COMMA;
      assign corr_off_evt[ch] = st_reg == CORR_ONE_COMMA &&
                                st_next == CORR_OFF;

      // Only a data character right after a comma is swapped
      assign sub = idle_mode && corr_en[ch] && tx_prev_comma_reg &&
                   !tc.k && tc.data == D16_2;

      // Transmit character register
      always_ff @(posedge clk or negedge rst_b) begin
         if (!rst_b) begin
            tx_prev_comma_reg <= 1'b0;
            tx_char_o[ch]     <= '0;
         end else begin
            tx_prev_comma_reg  <= tx_comma;
            tx_char_o[ch].k    <= tc.k;
            tx_char_o[ch].data <= sub ? D5_6 : tc.data;
         end
      end

      // Receive idle classification, flagged the cycle after the data character
      always_ff @(posedge clk or negedge rst_b) begin
         if (!rst_b) begin
            rx_prev_comma_reg <= 1'b0;
            rx_idle_o[ch]     <= 1'b0;
         end else begin
            rx_prev_comma_reg <= rc.k && !rc.cv && rc.data == K28_5;
            rx_idle_o[ch] <= idle_mode && rx_prev_comma_reg &&
                             !rc.k && !rc.cv &&
                             !(busy_pass_mode && rc.data == D10_1);
         end
      end

      // Generator; held at seed while the test is off
      always_ff @(posedge clk or negedge rst_b) begin
         if (!rst_b) begin
            gen_reg          <= PRBS_SEED;
            tx_test_bit_o[ch] <= 1'b0;
         end else if (test_pattern_enable) begin
            gen_reg <= {gen_reg[PRBS_LEN-2:0],
                        gen_reg[PRBS_TAPA] ^ gen_reg[PRBS_TAPB]};
            tx_test_bit_o[ch] <= gen_reg[PRBS_LEN-1];
         end else begin
            gen_reg          <= PRBS_SEED;
            tx_test_bit_o[ch] <= 1'b0;
         end
      end

      // Self-seeding checker: history of received bits predicts next
      assign predict = chk_reg[PRBS_TAPA] ^ chk_reg[PRBS_TAPB];
      assign chk_sync[ch] = cnt_reg == SYNC_CNT;
      assign prbs_err_evt[ch] = test_pattern_enable && chk_sync[ch] &&
                                rx_test_bit_i[ch] != predict;

      // Seven bits must arrive before any comparison counts
      always_ff @(posedge clk or negedge rst_b) begin
         if (!rst_b) begin
            chk_reg <= '0;
            cnt_reg <= '0;
         end else if (test_pattern_enable) begin
            chk_reg <= {chk_reg[PRBS_LEN-2:0], rx_test_bit_i[ch]};
            if (!chk_sync[ch]) cnt_reg <= cnt_reg + 3'h1;
         end else begin
            chk_reg <= '0;
            cnt_reg <= '0;
         end
      end
   end

endmodule // gicp_idle_prbs

// ==== sim/gicp_checker.sv ====
`timescale 1ns/10ps
module gicp_checker
   import gicp_pkg::*;
#(
   parameter int NCH = 8
) (
   // Clock and reset
   input wire logic                    clk,
   input wire logic                    rst_b,
   // Mode pins
   input wire logic                    gigabit_idle_mode_pin,
   input wire logic                    busy_pass_enable_pin,
   input wire logic                    test_pattern_enable,
   // Character paths and pattern bits
   input wire gicp_char_t [NCH-1:0]    tx_char_i,
   input wire gicp_char_t [NCH-1:0]    tx_char_o,
   input wire gicp_rx_char_t [NCH-1:0] rx_char_i,
   input wire logic [NCH-1:0]          rx_idle_o,
   input wire logic [NCH-1:0]          tx_test_bit_o
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic [3:0] run_cnt;

   // Cycles of pattern run; the recurrence needs seven settled bits
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) run_cnt <= 4'h0;
      else if (!test_pattern_enable) run_cnt <= 4'h0;
      else if (run_cnt != 4'hf) run_cnt <= run_cnt + 4'h1;
   end

   // Channel 0 stands for all; the channels share one design
   sequence s_k; tx_char_i[0] == {1'b1, K28_5}; endsequence
   sequence s_d; !tx_char_i[0].k; endsequence
   sequence s_fix;
      gigabit_idle_mode_pin && tx_char_i[0] == {1'b0, D16_2};
   endsequence
   property p_pass;
      tx_char_i[0] != {1'b0, D16_2} |=> tx_char_o[0] == $past(tx_char_i[0]);
   endproperty
   a_pass: assert property (p_pass) else $error("tx char altered");
   property p_fix; s_d ##1 s_d ##1 s_k ##1 s_fix |=> tx_char_o[0].data == D5_6;
   endproperty
   a_fix: assert property (p_fix) else $error("idle not fixed");
   property p_run; s_k ##1 s_k ##1 s_fix |=> tx_char_o[0].data == D16_2;
   endproperty
   a_run: assert property (p_run) else $error("fixed in comma run");
   property p_one;
      s_k ##1 s_k ##1 s_d ##1 s_k ##1 s_fix |=> tx_char_o[0].data == D16_2;
   endproperty
   a_one: assert property (p_one) else $error("restored too soon");
   property p_rx;
      gigabit_idle_mode_pin && rx_char_i[0] == {2'b01, K28_5}
      ##1 rx_char_i[0] == {2'b00, D5_6} |=> rx_idle_o[0];
   endproperty
   a_rx: assert property (p_rx) else $error("idle not seen");
   property p_busy;
      rx_char_i[0] == {2'b01, K28_5} ##1 busy_pass_enable_pin
      && rx_char_i[0] == {2'b00, D10_1} |=> !rx_idle_o[0];
   endproperty
   a_busy: assert property (p_busy) else $error("busy pair idle");
   property p_lfsr; run_cnt == 4'hf |-> tx_test_bit_o[0] ==
      ($past(tx_test_bit_o[0], 7) ^ $past(tx_test_bit_o[0], 6));
   endproperty
   a_lfsr: assert property (p_lfsr) else $error("bad pattern");
   property p_all;
      run_cnt == 4'hf |-> tx_test_bit_o == {NCH{tx_test_bit_o[0]}};
   endproperty
   a_all: assert property (p_all) else $error("channels differ");
endmodule // gicp_checker

bind gicp_idle_prbs gicp_checker #(.NCH(NCH)) gicp_checker_inst (
   .clk, .rst_b, .gigabit_idle_mode_pin, .busy_pass_enable_pin,
   .test_pattern_enable, .tx_char_i, .tx_char_o, .rx_char_i, .rx_idle_o,
   .tx_test_bit_o);

// ==== sim/gicp_proto_dev.sv ====
`timescale 1ns/10ps
module gicp_proto_dev
   import gicp_pkg::*;
#(
   parameter int NCH = 8
) (
   // Bench command
   input wire gicp_char_t        send_char,
   input wire logic              flip,
   // Block side
   output gicp_char_t [NCH-1:0]  tx_char,
   input wire logic [NCH-1:0]    tx_bit,
   output logic [NCH-1:0]        rx_bit
);
   // One stream on all channels, so every state machine sees the same run
   assign tx_char = {NCH{send_char}};
   // Serial loop back; flip models a line error
   assign rx_bit = tx_bit ^ {NCH{flip}};
endmodule // gicp_proto_dev

// ==== sim/gicp_idle_prbs_tb.sv ====
`timescale 1ns/10ps
module gicp_idle_prbs_tb;
   import gicp_pkg::*;
   localparam int NCH = 2;
   logic                    clk = 1'b0;
   logic                    rst_b = 1'b0;
   logic                    mode_pin = 1'b1;
   logic                    busy_pin = 1'b0;
   logic                    test_en = 1'b0;
   logic                    flip = 1'b0;
   logic                    irq, err;
   logic [31:0]             rd;
   logic [NCH-1:0]          rx_idle_o, tx_bit, rx_bit;
   gicp_apb_req_t           apb_req = '0;
   gicp_apb_rsp_t           apb_rsp;
   gicp_char_t              send_char = '0;
   gicp_char_t [NCH-1:0]    tx_char_i, tx_char_o;
   gicp_rx_char_t [NCH-1:0] rx_char_i = '0;
   int                      n_fail = 0;
   int                      n_tests = 0;

   always #20 clk = ~clk;
   gicp_idle_prbs #(.NCH(NCH)) gicp_idle_prbs_inst (.clk, .rst_b, .apb_req,
      .apb_rsp, .gigabit_idle_mode_pin(mode_pin),
      .busy_pass_enable_pin(busy_pin),
      .test_pattern_enable(test_en), .tx_char_i, .tx_char_o, .rx_char_i,
      .rx_idle_o, .tx_test_bit_o(tx_bit), .rx_test_bit_i(rx_bit), .irq);
   gicp_proto_dev #(.NCH(NCH)) gicp_proto_dev_inst (.send_char, .flip,
      .tx_char(tx_char_i), .tx_bit, .rx_bit);

   task automatic summarize();
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One transfer; no wait count, the watchdog cuts a hang
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      apb_req <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk);
      apb_req.penable <= 1'b1;
      do @(posedge clk); while (apb_rsp.pready !== 1'b1);
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req <= '0;
      #1;
   endtask
   // Send a character and judge the output for the one before it
   task automatic put(input logic [8:0] c, input logic [7:0] e);
      @(posedge clk);
      send_char <= c;
      #1 chk({16'h0, tx_char_o[1].data, tx_char_o[0].data},
             {16'h0, e, e});
   endtask
   task automatic rput(input logic [9:0] c, input logic e);
      @(posedge clk);
      rx_char_i <= {NCH{c}};
      #1 chk({30'h0, rx_idle_o}, {30'h0, e, e});
   endtask

   task automatic t_regs();
      apb(1'b0, ADDR_CHAN_STAT, '0);
      chk(rd, 32'h3);
      apb(1'b0, 8'h10, '0);
      chk({rd[30:0], err}, 32'h1);
      apb(1'b1, ADDR_IRQ_MASK, 32'hffff_ffff);
      apb(1'b0, ADDR_IRQ_MASK, '0);
      chk(rd, 32'hffff_ffff);
      apb(1'b1, ADDR_IRQ_MASK, '0);
   endtask
   // Comma runs stop the fix; the two data characters after them restart it
   task automatic t_tx();
      put(9'h1bc, 8'h00);
      put(9'h050, 8'hbc);
      put(9'h1bc, 8'hc5);
      put(9'h1bc, 8'hbc);
      put(9'h050, 8'hbc);
      put(9'h1bc, 8'h50);
      put(9'h050, 8'hbc);
      put(9'h000, 8'h50);
      put(9'h1bc, 8'h00);
      put(9'h050, 8'hbc);
      put(9'h000, 8'hc5);
      apb(1'b0, ADDR_IRQ_STAT, '0);
      chk(rd, 32'h300);
      apb(1'b1, ADDR_IRQ_STAT, 32'h300);
   endtask
   task automatic t_mode();
      mode_pin <= 1'b0;
      put(9'h1bc, 8'h00);
      put(9'h050, 8'hbc);
      put(9'h000, 8'h50);
      apb(1'b1, ADDR_MODE_CTRL, 32'h8000);
      apb(1'b0, ADDR_MODE_CTRL, '0);
      chk(rd, 32'h8000);
      put(9'h1bc, 8'h00);
      put(9'h050, 8'hbc);
      put(9'h000, 8'hc5);
      apb(1'b1, ADDR_MODE_CTRL, '0);
      mode_pin <= 1'b1;
   endtask
   task automatic t_rx();
      rput(10'h1bc, 1'b0);
      rput(10'h02a, 1'b0);
      rput(10'h000, 1'b1);
      busy_pin <= 1'b1;
      rput(10'h1bc, 1'b0);
      rput(10'h02a, 1'b0);
      rput(10'h1bc, 1'b0);
      rput(10'h0c5, 1'b0);
      rput(10'h1bc, 1'b1);
      rput(10'h2c5, 1'b0);
      rput(10'h000, 1'b0);
      mode_pin <= 1'b0;
      rput(10'h1bc, 1'b0);
      rput(10'h0c5, 1'b0);
      rput(10'h000, 1'b0);
      mode_pin <= 1'b1;
   endtask
   // Stale bits before the loop fills may trip the checker, so clear first
   task automatic t_prbs();
      logic [6:0] ref_lfsr;
      ref_lfsr = PRBS_SEED;
      test_en <= 1'b1;
      // Loopback alone would pass a stuck generator, so check the bits
      repeat (12) begin
         @(posedge clk);
         #1 chk({30'h0, tx_bit}, {30'h0, {NCH{ref_lfsr[6]}}});
         ref_lfsr = {ref_lfsr[5:0], ref_lfsr[6] ^ ref_lfsr[5]};
      end
      apb(1'b1, ADDR_IRQ_STAT, 32'h3);
      apb(1'b0, ADDR_CHAN_STAT, '0);
      chk(rd, 32'h303);
      apb(1'b1, ADDR_IRQ_MASK, 32'h3);
      apb(1'b0, ADDR_IRQ_STAT, '0);
      chk({rd[30:0], irq}, 32'h0);
      @(posedge clk) flip <= 1'b1;
      @(posedge clk) flip <= 1'b0;
      repeat (12) @(posedge clk);
      apb(1'b0, ADDR_IRQ_STAT, '0);
      chk({rd[30:0], irq}, 32'h7);
      apb(1'b1, ADDR_IRQ_MASK, '0);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, ADDR_IRQ_STAT, 32'h3);
      apb(1'b0, ADDR_IRQ_STAT, '0);
      chk(rd, 32'h0);
      test_en <= 1'b0;
   endtask

   initial begin
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      t_regs();
      t_tx();
      t_mode();
      t_rx();
      t_prbs();
      summarize();
   end
   // Watchdog, over twenty times the expected run
   initial begin
      repeat (3000) @(posedge clk);
      n_fail++;
      summarize();
   end
endmodule // gicp_idle_prbs_tb
